// *** design/mcr_mac_config.sv ***
`timescale 1ns/100ps
module mcr_mac_config (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic [31:0]              regAddr,
  input  wire logic [31:0]              regWrData,
  input  wire logic                     regWrStb,
  input  wire logic                     regRdStb,
  output logic      [31:0]              regRdData,
  input  wire logic [mcr_pkg::NIB_W-1:0] phyRxData,
  input  wire logic                     phyRxDv,
  input  wire logic [mcr_pkg::NIB_W-1:0] txData,
  input  wire logic                     txEn,
  input  wire logic                     txPauseReq,
  input  wire logic                     rxPauseFrame,
  input  wire logic                     rxCtrlFrame,
  output logic                          macSoftReset,
  output logic                          txRandomGenReset,
  output logic                          ctrlSublayerRxReset,
  output logic                          rxFunctionReset,
  output logic                          ctrlSublayerTxReset,
  output logic                          txFunctionReset,
  output logic                          internalLoopback,
  output logic                          txPauseSend,
  output logic                          rxPauseAct,
  output logic                          passCurrentFrame,
  output logic                          syncRxEnable,
  output logic [mcr_pkg::NIB_W-1:0]     macRxData,
  output logic                          macRxDv,
  output logic                          rxDeliver,
  output logic [mcr_pkg::NIB_W-1:0]     phyTxData,
  output logic                          phyTxEn
);
  localparam int NW = mcr_pkg::NIB_W;

  // host register and its next value
  logic [31:0]   ctrl_r;
  logic [31:0]   ctrl_nxt;
  logic [31:0]   rdData_r;
  logic [31:0]   rdData_nxt;
  logic          wrHit;
  logic          rdHit;

  // decoded control bits
  logic          softBit;
  logic          randBit;
  logic          csRxBit;
  logic          rxFnBit;
  logic          csTxBit;
  logic          txFnBit;
  logic          loopBit;
  logic          txPauseBit;
  logic          rxPauseBit;
  logic          passAllBit;
  logic          rxOnBit;

  // pin synchronisers for the receive stream
  logic [NW-1:0] rxDataMeta_r;
  logic [NW-1:0] rxDataSync_r;
  logic          rxDvMeta_r;
  logic          rxDvSync_r;
  logic [NW-1:0] rxDataMeta_nxt;
  logic [NW-1:0] rxDataSync_nxt;
  logic          rxDvMeta_nxt;
  logic          rxDvSync_nxt;

  // internal hold terms per sub-block
  logic          rxHold;
  logic          rxCtlHold;
  logic          txHold;
  logic          txCtlHold;
  logic          muxDv;
  logic [NW-1:0] muxData;

  // registered outputs
  logic          softOut_r;
  logic          randOut_r;
  logic          csRxOut_r;
  logic          rxFnOut_r;
  logic          csTxOut_r;
  logic          txFnOut_r;
  logic          loopOut_r;
  logic          txPause_r;
  logic          rxPause_r;
  logic          pass_r;
  logic          syncEn_r;
  logic [NW-1:0] rxData_r;
  logic          rxDv_r;
  logic          deliver_r;
  logic [NW-1:0] txData_r;
  logic          txEn_r;
  logic          softOut_nxt;
  logic          randOut_nxt;
  logic          csRxOut_nxt;
  logic          rxFnOut_nxt;
  logic          csTxOut_nxt;
  logic          txFnOut_nxt;
  logic          loopOut_nxt;
  logic          txPause_nxt;
  logic          rxPause_nxt;
  logic          pass_nxt;
  logic          syncEn_nxt;
  logic [NW-1:0] rxData_nxt;
  logic          rxDv_nxt;
  logic          deliver_nxt;
  logic [NW-1:0] txData_nxt;
  logic          txEn_nxt;

  mcr_sync_if syncIf ();

  // field decode
  assign softBit    = ctrl_r[mcr_pkg::BIT_SOFT_RST];
  assign randBit    = ctrl_r[mcr_pkg::BIT_RAND_RST];
  assign csRxBit    = ctrl_r[mcr_pkg::BIT_CSRX_RST];
  assign rxFnBit    = ctrl_r[mcr_pkg::BIT_RXFN_RST];
  assign csTxBit    = ctrl_r[mcr_pkg::BIT_CSTX_RST];
  assign txFnBit    = ctrl_r[mcr_pkg::BIT_TXFN_RST];
  assign loopBit    = ctrl_r[mcr_pkg::BIT_LOOPBACK];
  assign txPauseBit = ctrl_r[mcr_pkg::BIT_TX_PAUSE];
  assign rxPauseBit = ctrl_r[mcr_pkg::BIT_RX_PAUSE];
  assign passAllBit = ctrl_r[mcr_pkg::BIT_PASS_ALL];
  assign rxOnBit    = ctrl_r[mcr_pkg::BIT_RX_ON];

  // bus decode
  assign wrHit = regWrStb && (regAddr == mcr_pkg::REG_ADDR);
  assign rdHit = regRdStb && (regAddr == mcr_pkg::REG_ADDR);

  // host register, soft bits never clear it
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wrHit) begin
      ctrl_nxt = regWrData & mcr_pkg::WRITE_MASK;
    end
    rdData_nxt = mcr_pkg::READ_IDLE;
    if (rdHit) begin
      rdData_nxt = ctrl_r & mcr_pkg::WRITE_MASK;
    end
  end

  // only hardware reset reaches this group
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r   <= mcr_pkg::RESET_VALUE;
      rdData_r <= mcr_pkg::READ_IDLE;
    end else begin
      ctrl_r   <= ctrl_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  // sub-block holds, soft reset overrides all
  assign rxHold    = softBit | rxFnBit;
  assign rxCtlHold = softBit | csRxBit;
  assign txHold    = softBit | txFnBit;
  assign txCtlHold = softBit | csTxBit;

  // two-flop synchroniser on the phy receive pins
  always_comb begin
    rxDataMeta_nxt = phyRxData;
    rxDvMeta_nxt   = phyRxDv;
    rxDataSync_nxt = rxDataMeta_r;
    rxDvSync_nxt   = rxDvMeta_r;
  end

  // synchroniser registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxDataMeta_r <= mcr_pkg::NIB_ZERO;
      rxDvMeta_r   <= 1'b0;
      rxDataSync_r <= mcr_pkg::NIB_ZERO;
      rxDvSync_r   <= 1'b0;
    end else begin
      rxDataMeta_r <= rxDataMeta_nxt;
      rxDvMeta_r   <= rxDvMeta_nxt;
      rxDataSync_r <= rxDataSync_nxt;
      rxDvSync_r   <= rxDvSync_nxt;
    end
  end

  // receive stream source select
  assign muxDv   = loopBit ? (txEn & ~txHold) : rxDvSync_r;
  assign muxData = loopBit ? txData : rxDataSync_r;

  // frame-aligned receive enable
  assign syncIf.receiverOn = rxOnBit;
  assign syncIf.rxDv       = muxDv;
  assign syncIf.holdReset  = rxHold;

  mcr_rx_enable_sync uSync (
    .clock (clock),
    .rst   (rst),
    .port  (syncIf)
  );

  // output stage next values
  always_comb begin
    softOut_nxt = softBit;
    randOut_nxt = softBit | randBit;
    csRxOut_nxt = rxCtlHold;
    rxFnOut_nxt = rxHold;
    csTxOut_nxt = txCtlHold;
    txFnOut_nxt = txHold;
    loopOut_nxt = loopBit;
    txPause_nxt = txPauseReq & txPauseBit & ~txCtlHold;
    rxPause_nxt = rxPauseFrame & rxPauseBit & ~rxCtlHold;
    pass_nxt    = (rxCtrlFrame ? passAllBit : 1'b1) & ~rxHold;
    syncEn_nxt  = syncIf.syncRxEn;
    rxDv_nxt    = muxDv & ~rxHold;
    rxData_nxt  = rxHold ? mcr_pkg::NIB_ZERO : muxData;
    deliver_nxt = muxDv & syncIf.syncRxEn & ~rxHold;
    txEn_nxt    = txEn & ~txHold & ~loopBit;
    txData_nxt  = txEn_nxt ? txData : mcr_pkg::NIB_ZERO;
  end

  // output registers, reset asserts the hold lines
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      softOut_r <= 1'b1;
      randOut_r <= 1'b1;
      csRxOut_r <= 1'b1;
      rxFnOut_r <= 1'b1;
      csTxOut_r <= 1'b1;
      txFnOut_r <= 1'b1;
      loopOut_r <= 1'b0;
      txPause_r <= 1'b0;
      rxPause_r <= 1'b0;
      pass_r    <= 1'b0;
      syncEn_r  <= 1'b0;
      rxDv_r    <= 1'b0;
      rxData_r  <= mcr_pkg::NIB_ZERO;
      deliver_r <= 1'b0;
      txEn_r    <= 1'b0;
      txData_r  <= mcr_pkg::NIB_ZERO;
    end else begin
      softOut_r <= softOut_nxt;
      randOut_r <= randOut_nxt;
      csRxOut_r <= csRxOut_nxt;
      rxFnOut_r <= rxFnOut_nxt;
      csTxOut_r <= csTxOut_nxt;
      txFnOut_r <= txFnOut_nxt;
      loopOut_r <= loopOut_nxt;
      txPause_r <= txPause_nxt;
      rxPause_r <= rxPause_nxt;
      pass_r    <= pass_nxt;
      syncEn_r  <= syncEn_nxt;
      rxDv_r    <= rxDv_nxt;
      rxData_r  <= rxData_nxt;
      deliver_r <= deliver_nxt;
      txEn_r    <= txEn_nxt;
      txData_r  <= txData_nxt;
    end
  end

  // port drive
  assign regRdData           = rdData_r;
  assign macSoftReset        = softOut_r;
  assign txRandomGenReset    = randOut_r;
  assign ctrlSublayerRxReset = csRxOut_r;
  assign rxFunctionReset     = rxFnOut_r;
  assign ctrlSublayerTxReset = csTxOut_r;
  assign txFunctionReset     = txFnOut_r;
  assign internalLoopback    = loopOut_r;
  assign txPauseSend         = txPause_r;
  assign rxPauseAct          = rxPause_r;
  assign passCurrentFrame    = pass_r;
  assign syncRxEnable        = syncEn_r;
  assign macRxDv             = rxDv_r;
  assign macRxData           = rxData_r;
  assign rxDeliver           = deliver_r;
  assign phyTxEn             = txEn_r;
  assign phyTxData           = txData_r;

  // first cycle after reset release
  logic firstCyc_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      firstCyc_r <= 1'b1;
    end else begin
      firstCyc_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_soft_reset_init: assert property (
    firstCyc_r |-> (softBit && macSoftReset && rxFunctionReset && txFunctionReset))
    else $error("soft reset not set after hardware reset");

  a_soft_holds_all: assert property (
    (softBit && !wrHit) |=> (ctrlSublayerRxReset && rxFunctionReset && ctrlSublayerTxReset
                            && txFunctionReset && txRandomGenReset) [*2])
    else $error("sub-module left running under soft reset");

  a_host_survives: assert property (
    !wrHit |=> $stable(ctrl_r))
    else $error("host register changed without a write");

  a_rand_reset: assert property (
    (wrHit && regWrData[mcr_pkg::BIT_RAND_RST]) |=> ##1 txRandomGenReset)
    else $error("random generator reset not asserted");

  a_sub_resets: assert property (
    (wrHit && !regWrData[mcr_pkg::BIT_SOFT_RST]) |=> ##1
      (ctrlSublayerRxReset == $past(regWrData[mcr_pkg::BIT_CSRX_RST], 2))
      && (rxFunctionReset == $past(regWrData[mcr_pkg::BIT_RXFN_RST], 2))
      && (ctrlSublayerTxReset == $past(regWrData[mcr_pkg::BIT_CSTX_RST], 2))
      && (txFunctionReset == $past(regWrData[mcr_pkg::BIT_TXFN_RST], 2)))
    else $error("sub-block reset does not follow its bit");

  a_loopback_route: assert property (
    (loopBit && txEn && !txHold && !rxHold) |=> (macRxDv && !phyTxEn && macRxData == $past(txData)))
    else $error("loopback did not route transmit to receive");

  a_tx_pause_gate: assert property (
    txPauseSend |-> $past(txPauseBit && txPauseReq))
    else $error("pause frame sent while blocked");

  a_rx_pause_gate: assert property (
    (!rxPauseBit || rxCtlHold) |=> !rxPauseAct)
    else $error("received pause acted on while ignored");

  a_pass_ctrl: assert property (
    (rxCtrlFrame && !rxHold) |=> (passCurrentFrame == $past(passAllBit)))
    else $error("pass indication wrong for control frame");

  a_deliver_sync: assert property (
    rxDeliver |-> ($past(syncIf.syncRxEn) && macRxDv && syncIf.frameBusy))
    else $error("frame delivered without synced enable");

  a_reserved_zero: assert property (
    rdHit |=> ((regRdData & ~mcr_pkg::WRITE_MASK) == mcr_pkg::READ_IDLE))
    else $error("reserved bits read nonzero");

  c_soft_release: cover property ($fell(softBit));
  c_loop_deliver: cover property (loopOut_r && rxDeliver);
  c_pause_sent:   cover property (txPauseSend);
  c_frame_kept:   cover property (rxDeliver [*3] ##1 !macRxDv);
endmodule // mcr_mac_config

// *** design/mcr_rx_enable_sync.sv ***
`timescale 1ns/100ps
module mcr_rx_enable_sync (
  input  wire logic clock,
  input  wire logic rst,
  mcr_sync_if.syn   port
);
  mcr_pkg::mcr_rx_state_t state_r;
  mcr_pkg::mcr_rx_state_t state_nxt;
  logic                   syncEn_r;
  logic                   syncEn_nxt;

  // enable only changes between frames or when holdReset clears it
  always_comb begin
    state_nxt  = state_r;
    syncEn_nxt = syncEn_r;
    case (state_r)
      mcr_pkg::ST_IDLE: begin
        syncEn_nxt = port.receiverOn;
        if (port.rxDv) begin
          state_nxt  = syncEn_r ? mcr_pkg::ST_RECV : mcr_pkg::ST_DROP;
          syncEn_nxt = syncEn_r;
        end
      end
      mcr_pkg::ST_RECV, mcr_pkg::ST_DROP: begin
        if (!port.rxDv) begin
          state_nxt  = mcr_pkg::ST_IDLE;
          syncEn_nxt = port.receiverOn;
        end
      end
      default: begin
        state_nxt  = mcr_pkg::ST_IDLE;
        syncEn_nxt = 1'b0;
      end
    endcase
    if (port.holdReset) begin
      state_nxt  = mcr_pkg::ST_IDLE;
      syncEn_nxt = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r  <= mcr_pkg::ST_IDLE;
      syncEn_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      syncEn_r <= syncEn_nxt;
    end
  end

  assign port.syncRxEn  = syncEn_r;
  assign port.frameBusy = (state_r != mcr_pkg::ST_IDLE);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_enable_frame_hold: assert property (
    (state_r == mcr_pkg::ST_RECV && port.rxDv && !port.holdReset) |=> syncEn_r)
    else $error("sync enable dropped inside a frame");

  a_off_when_idle: assert property (
    (state_r == mcr_pkg::ST_IDLE && !port.rxDv && !port.receiverOn) |=> !syncEn_r)
    else $error("sync enable set while receiver off");

  c_frame_dropped: cover property (state_r == mcr_pkg::ST_DROP ##1 state_r == mcr_pkg::ST_IDLE);
endmodule // mcr_rx_enable_sync

// *** pkg/mcr_pkg.sv ***
package mcr_pkg;
  // register map, byte address of the only register
  localparam logic [31:0] REG_ADDR    = 32'hFF80_0400;
  localparam logic [31:0] WRITE_MASK  = 32'h0000_CF1F;
  localparam logic [31:0] RESET_VALUE = 32'h0000_8000;
  localparam logic [31:0] READ_IDLE   = 32'h0000_0000;
  // field positions
  localparam int BIT_SOFT_RST  = 15;
  localparam int BIT_RAND_RST  = 14;
  localparam int BIT_CSRX_RST  = 11;
  localparam int BIT_RXFN_RST  = 10;
  localparam int BIT_CSTX_RST  = 9;
  localparam int BIT_TXFN_RST  = 8;
  localparam int BIT_LOOPBACK  = 4;
  localparam int BIT_TX_PAUSE  = 3;
  localparam int BIT_RX_PAUSE  = 2;
  localparam int BIT_PASS_ALL  = 1;
  localparam int BIT_RX_ON     = 0;
  // nibble stream width toward the phy
  localparam int NIB_W = 4;
  localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
  // frame tracking for the receive enable
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RECV = 3'h2,
    ST_DROP = 3'h4
  } mcr_rx_state_t;
endpackage

// *** pkg/mcr_sync_if.sv ***
`timescale 1ns/100ps
interface mcr_sync_if;
  logic receiverOn;
  logic rxDv;
  logic holdReset;
  logic syncRxEn;
  logic frameBusy;
  modport ctl (output receiverOn, output rxDv, output holdReset,
               input syncRxEn, input frameBusy);
  modport syn (input receiverOn, input rxDv, input holdReset,
               output syncRxEn, output frameBusy);
endinterface

// *** tb/mcr_phy_model.sv ***
`timescale 1ns/100ps
// behavioural phy: sends receive frames on request and takes transmit nibbles
module mcr_phy_model (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      go,
  input  wire logic [7:0]                len,
  input  wire logic [mcr_pkg::NIB_W-1:0] phyTxData,
  input  wire logic                      phyTxEn,
  output logic      [mcr_pkg::NIB_W-1:0] phyRxData,
  output logic                           phyRxDv,
  output int                             txTaken,
  output int                             txSum
);
  int left;
  int pos;
  int n;
  int p;
  int v;
  // one nibble per cycle; between frames the data lines keep toggling
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      phyRxDv   <= 1'b0;
      phyRxData <= 4'h0;
      left      <= 0;
      pos       <= 0;
      txTaken   <= 0;
      txSum     <= 0;
    end else begin
      n = go ? int'(len) : left;
      p = go ? 0 : pos;
      v = p * 5 + 3;
      if (n != 0) begin
        phyRxDv   <= 1'b1;
        phyRxData <= v[mcr_pkg::NIB_W-1:0];
        left      <= n - 1;
        pos       <= p + 1;
      end else begin
        phyRxDv   <= 1'b0;
        phyRxData <= ~phyRxData;
      end
      // count and add up nibbles that reach the line
      if (phyTxEn === 1'b1) begin
        txTaken <= txTaken + 1;
        txSum   <= txSum + int'(phyTxData);
      end
    end
  end
endmodule // mcr_phy_model

// *** tb/test_mac_config_reset_flow_ctrl.sv ***
`timescale 1ns/100ps
module test_mac_config_reset_flow_ctrl;
  localparam logic [31:0] OTHER = 32'hFF80_0404;
  logic                      clock, rst, regWrStb, regRdStb, go;
  logic [31:0]               regAddr, regWrData, regRdData, d;
  logic [mcr_pkg::NIB_W-1:0] phyRxData, txData, macRxData, phyTxData;
  logic                      phyRxDv, txEn, txPauseReq, rxPauseFrame, rxCtrlFrame;
  logic                      macSoftReset, txRandomGenReset, ctrlSublayerRxReset, rxFunctionReset;
  logic                      ctrlSublayerTxReset, txFunctionReset, internalLoopback, txPauseSend;
  logic                      rxPauseAct, passCurrentFrame, syncRxEnable, macRxDv, rxDeliver, phyTxEn;
  logic [7:0]                len;
  int                        txTaken, txSum, fails, checked, cntDv, cntDel, sumRx, cfg, i, d0, seedDummy;

  mcr_mac_config u_dut (.clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .phyRxData(phyRxData),
    .phyRxDv(phyRxDv), .txData(txData), .txEn(txEn), .txPauseReq(txPauseReq),
    .rxPauseFrame(rxPauseFrame), .rxCtrlFrame(rxCtrlFrame), .macSoftReset(macSoftReset),
    .txRandomGenReset(txRandomGenReset), .ctrlSublayerRxReset(ctrlSublayerRxReset),
    .rxFunctionReset(rxFunctionReset), .ctrlSublayerTxReset(ctrlSublayerTxReset),
    .txFunctionReset(txFunctionReset), .internalLoopback(internalLoopback),
    .txPauseSend(txPauseSend), .rxPauseAct(rxPauseAct), .passCurrentFrame(passCurrentFrame),
    .syncRxEnable(syncRxEnable), .macRxData(macRxData), .macRxDv(macRxDv),
    .rxDeliver(rxDeliver), .phyTxData(phyTxData), .phyTxEn(phyTxEn));

  mcr_phy_model u_phy (.clock(clock), .rst(rst), .go(go), .len(len), .phyTxData(phyTxData),
    .phyTxEn(phyTxEn), .phyRxData(phyRxData), .phyRxDv(phyRxDv), .txTaken(txTaken), .txSum(txSum));

  // clock generation
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // receive side tallies
  always @(posedge clock) begin
    if (macRxDv === 1'b1) begin
      cntDv = cntDv + 1;
      sumRx = sumRx + int'(macRxData);
    end
    if (rxDeliver === 1'b1) cntDel = cntDel + 1;
  end

  function automatic logic [mcr_pkg::NIB_W-1:0] nib_of(input int k);
    int v;
    v = k * 5 + 3;
    return v[mcr_pkg::NIB_W-1:0];
  endfunction

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // register bus write; model copy keeps only writable bits
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clock);
    regAddr   <= a;
    regWrData <= v;
    regWrStb  <= 1'b1;
    @(posedge clock);
    regWrStb <= 1'b0;
    if (a == mcr_pkg::REG_ADDR) cfg = int'(v & mcr_pkg::WRITE_MASK);
  endtask

  task automatic rd_check(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clock);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge clock);
    regRdStb <= 1'b0;
    #1 check(regRdData, exp);
  endtask

  task automatic check_cfg;
    @(posedge clock);
    #1 check(macSoftReset, cfg[15]);
    check(txRandomGenReset, cfg[15] | cfg[14]);
    check(ctrlSublayerRxReset, cfg[15] | cfg[11]);
    check(rxFunctionReset, cfg[15] | cfg[10]);
    check(ctrlSublayerTxReset, cfg[15] | cfg[9]);
    check(txFunctionReset, cfg[15] | cfg[8]);
    check(internalLoopback, cfg[4]);
  endtask

  // random flow-control requests under the current setting
  task automatic flow_cycles;
    logic [31:0] a;
    repeat (6) begin
      a = $urandom;
      @(posedge clock);
      txPauseReq   <= a[0];
      rxPauseFrame <= a[1];
      rxCtrlFrame  <= a[2];
      @(posedge clock);
      #1 check(txPauseSend, a[0] & cfg[3] & !(cfg[15] | cfg[9]));
      check(rxPauseAct, a[1] & cfg[2] & !(cfg[15] | cfg[11]));
      check(passCurrentFrame, (cfg[15] | cfg[10]) ? 1'b0 : (a[2] ? cfg[1] : 1'b1));
    end
  endtask

  task automatic send(input int l);
    @(posedge clock);
    go  <= 1'b1;
    len <= 8'(l);
    @(posedge clock);
    go <= 1'b0;
  endtask

  task automatic wait_idle;
    int k;
    for (k = 0; k < 80; k++) begin
      @(posedge clock);
      if (k > 4 && phyRxDv !== 1'b1 && macRxDv !== 1'b1 && phyTxEn !== 1'b1) return;
    end
    fails++;
    $display("MISMATCH at %0t: stream never went idle", $time);
    print_verdict();
  endtask

  // one frame of 8 nibbles from the phy or from the transmitter
  task automatic run_case(input logic [31:0] c, input bit viaTx, input int eDv, input int eDel, input int eTx);
    int dv0, del0, tx0, s0, k, es, ts0;
    wr(mcr_pkg::REG_ADDR, c);
    repeat (4) @(posedge clock);
    #1 check(syncRxEnable, c[0] & !(c[15] | c[10]));
    dv0  = cntDv;
    del0 = cntDel;
    tx0  = txTaken;
    ts0  = txSum;
    s0   = sumRx;
    es   = 0;
    if (viaTx) begin
      for (k = 0; k < 8; k++) begin
        @(posedge clock);
        txEn   <= 1'b1;
        txData <= nib_of(k);
      end
      @(posedge clock);
      txEn <= 1'b0;
    end else
      send(8);
    wait_idle();
    for (k = 0; k < 8; k++) es += int'(nib_of(k));
    check(cntDv - dv0, eDv);
    check(cntDel - del0, eDel);
    check(txTaken - tx0, eTx);
    check(txSum - ts0, (eTx != 0) ? es : 0);
    if (eDv != 0) check(sumRx - s0, es);
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    {regWrStb, regRdStb, go, txEn, txPauseReq, rxPauseFrame, rxCtrlFrame} = '0;
    regAddr   = 32'h0;
    regWrData = 32'h0;
    txData    = 4'h0;
    len       = 8'h0;
    {fails, checked, cntDv, cntDel, sumRx} = '0;
    seedDummy = $urandom(67);
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    cfg = 32'h0000_8000;
    rd_check(mcr_pkg::REG_ADDR, cfg);
    check_cfg();
    for (i = 0; i < 12; i++) begin
      d = $urandom;
      if (i % 2 == 1) d = d & 32'hFFFF_33FF;
      wr(mcr_pkg::REG_ADDR, d);
      check_cfg();
      rd_check(mcr_pkg::REG_ADDR, cfg);
      flow_cycles();
    end
    wr(OTHER, $urandom);
    rd_check(mcr_pkg::REG_ADDR, cfg);
    rd_check(OTHER, 32'h0);
    @(posedge clock);
    {txPauseReq, rxPauseFrame, rxCtrlFrame} <= 3'b000;
    run_case(32'h0000_0001, 1'b0, 8, 8, 0);
    d0 = cntDel;
    send(8);
    repeat (3) @(posedge clock);
    wr(mcr_pkg::REG_ADDR, 32'h0);
    wait_idle();
    check(cntDel - d0, 8);
    run_case(32'h0000_0000, 1'b0, 8, 0, 0);
    run_case(32'h0000_0401, 1'b0, 0, 0, 0);
    run_case(32'h0000_8001, 1'b0, 0, 0, 0);
    run_case(32'h0000_0000, 1'b1, 0, 0, 8);
    run_case(32'h0000_0100, 1'b1, 0, 0, 0);
    run_case(32'h0000_8000, 1'b1, 0, 0, 0);
    run_case(32'h0000_0011, 1'b1, 8, 8, 0);
    // second hardware reset in mid-run restores the register
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    cfg = 32'h0000_8000;
    rd_check(mcr_pkg::REG_ADDR, cfg);
    check_cfg();
    print_verdict();
  end
endmodule // test_mac_config_reset_flow_ctrl
